// file: hdl/bdms_pkg.sv
// package: constants, types and field layout of the banked data memory
// Function
// - bank_select picks bank 0 or bank 1
// - lowest 32 locations per bank are SFRs
// - 20-7Fh bank 0 (20-6Fh on old variant), A0-BFh bank 1 RAM on large variant only
// - F0h-FFh mirrors 70h-7Fh on newer variants
// - RAM 8 bits wide, 80/96/128 words deep
// - RAM reachable directly and via indirect pointer
// - status readable at 03h and 83h
// - flag-updating writes skip zero/digit/carry bits
// - time-out and power-down bits ignore writes
// - clear of status zeroes top bits, sets zero
// - carry bits are active-low borrow on subtract
// - zero flag follows result equal zero
// - digit carry from fourth result bit
// - carry from top bit, rotates load it
package bdms_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int DIR_W  = 7;
  localparam int RAM_DEPTH_MAX = 128;
  localparam int RAM_IDX_W = 7;

  localparam logic [7:0] STATUS_OFS     = 8'h03;
  localparam logic [7:0] PTR_OFS        = 8'h04;
  localparam logic [6:0] SFR_TOP        = 7'h1F;
  localparam logic [7:0] STATUS_RESET   = 8'h18;
  localparam logic [7:0] PTR_RESET      = 8'h00;

  localparam int BIT_IND_BANK  = 7;
  localparam int BIT_UPPER_BANK = 6;
  localparam int BIT_BANK_SEL  = 5;
  localparam int BIT_TIMEOUT   = 4;
  localparam int BIT_POWERDOWN = 3;
  localparam int BIT_ZERO      = 2;
  localparam int BIT_DIGIT     = 1;
  localparam int BIT_CARRY     = 0;

  // bank 0 RAM windows and bank 1 windows
  localparam logic [7:0] B0_RAM_LO     = 8'h20;
  localparam logic [7:0] B0_RAM_HI_OLD = 8'h6F;
  localparam logic [7:0] B0_RAM_HI     = 8'h7F;
  localparam logic [7:0] B1_RAM_LO     = 8'hA0;
  localparam logic [7:0] B1_RAM_HI     = 8'hBF;
  localparam logic [7:0] COMMON_LO     = 8'hF0;
  localparam logic [7:0] COMMON_HI     = 8'hFF;
  localparam logic [7:0] COMMON_B0_LO  = 8'h70;
  localparam logic [6:0] B1_RAM_BASE   = 7'h60;

  typedef enum logic [1:0]
  {
    BDMS_VAR_OLD,
    BDMS_VAR_MID,
    BDMS_VAR_LARGE
  } bdms_variant_e;

  typedef enum logic [3:0]
  {
    BDMS_OP_NONE,
    BDMS_OP_ADD,
    BDMS_OP_SUB,
    BDMS_OP_AND,
    BDMS_OP_IOR,
    BDMS_OP_XOR,
    BDMS_OP_INC,
    BDMS_OP_DEC,
    BDMS_OP_RL,
    BDMS_OP_RR,
    BDMS_OP_CLR,
    BDMS_OP_MOVW,
    BDMS_OP_BCLR,
    BDMS_OP_BSET,
    BDMS_OP_SWAP,
    BDMS_OP_COMF
  } bdms_op_e;

  typedef struct packed
  {
    logic             valid;
    bdms_op_e         op;
    logic             indirect;
    logic [DIR_W-1:0] dir_addr;
    logic             use_literal;
    logic [7:0]       literal;
    logic [7:0]       w_val;
    logic [2:0]       bit_idx;
    logic             dest_file;
  } bdms_req_s;

  typedef struct packed
  {
    logic [7:0] result;
    logic       upd_z;
    logic       upd_dc;
    logic       upd_c;
    logic       z;
    logic       dc;
    logic       c;
  } bdms_alu_s;

  typedef struct packed
  {
    logic       valid;
    logic [7:0] result;
    logic [7:0] operand;
    logic [7:0] addr;
  } bdms_rsp_s;

endpackage

// file: hdl/bdms_gpr_ram.sv
// general purpose register file with bank windows and common area
`timescale 1ns/1ps
module bdms_gpr_ram
  import bdms_pkg::*;
#(
  parameter bdms_variant_e VARIANT = BDMS_VAR_MID
)
(
  input  wire logic              clock,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              wr_en,
  input  wire logic [DATA_W-1:0] wr_data,
  output logic      [DATA_W-1:0] rd_data,
  output logic                   hit
);

  logic [DATA_W-1:0]    mem [RAM_DEPTH_MAX];
  logic [RAM_IDX_W-1:0] idx;

  always_comb
  begin
    hit = 1'b0;
    idx = '0;
    if (addr >= B0_RAM_LO && addr <= B0_RAM_HI_OLD)
    begin
      hit = 1'b1;
      idx = 7'(addr - B0_RAM_LO);
    end
    else if (addr > B0_RAM_HI_OLD && addr <= B0_RAM_HI
             && VARIANT != BDMS_VAR_OLD)
    begin
      hit = 1'b1;
      idx = 7'(addr - B0_RAM_LO);
    end
    else if (addr >= B1_RAM_LO && addr <= B1_RAM_HI
             && VARIANT == BDMS_VAR_LARGE)
    begin
      hit = 1'b1;
      idx = B1_RAM_BASE + 7'(addr - B1_RAM_LO);
    end
    else if (addr >= COMMON_LO && VARIANT != BDMS_VAR_OLD)
    begin
      hit = 1'b1;
      idx = 7'(COMMON_B0_LO - B0_RAM_LO) + 7'(addr - COMMON_LO);
    end
  end

  // read is combinational so a read-modify-write fits one cycle
  assign rd_data = hit ? mem[idx] : '0;

  always_ff @(posedge clock)
  begin
    if (wr_en && hit)
    begin
      mem[idx] <= wr_data;
    end
  end

endmodule

// file: hdl/bdms_alu_flags.sv
// arithmetic result and zero, digit-carry and carry flag logic
`timescale 1ns/1ps
module bdms_alu_flags
  import bdms_pkg::*;
(
  input  bdms_op_e        op,
  input  wire logic [7:0] a,
  input  wire logic [7:0] w,
  input  wire logic [2:0] bit_idx,
  input  wire logic       carry_in,
  output bdms_alu_s       alu
);

  logic [8:0] sum;
  logic [4:0] nib;

  always_comb
  begin
    alu = '0;
    sum = '0;
    nib = '0;
    unique case (op)
      BDMS_OP_ADD:
      begin
        sum = {1'b0, a} + {1'b0, w};
        nib = {1'b0, a[3:0]} + {1'b0, w[3:0]};
        alu.result = sum[7:0];
        alu.c = sum[8];
        alu.dc = nib[4];
        {alu.upd_z, alu.upd_dc, alu.upd_c} = 3'b111;
      end
      BDMS_OP_SUB:
      begin
        // two's complement add: carry out high means no borrow
        sum = {1'b0, a} + {1'b0, ~w} + 9'h001;
        nib = {1'b0, a[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
        alu.result = sum[7:0];
        alu.c = sum[8];
        alu.dc = nib[4];
        {alu.upd_z, alu.upd_dc, alu.upd_c} = 3'b111;
      end
      BDMS_OP_AND:
      begin
        alu.result = a & w;
        alu.upd_z = 1'b1;
      end
      BDMS_OP_IOR:
      begin
        alu.result = a | w;
        alu.upd_z = 1'b1;
      end
      BDMS_OP_XOR:
      begin
        alu.result = a ^ w;
        alu.upd_z = 1'b1;
      end
      BDMS_OP_INC:
      begin
        alu.result = a + 8'h01;
        alu.upd_z = 1'b1;
      end
      BDMS_OP_DEC:
      begin
        alu.result = a - 8'h01;
        alu.upd_z = 1'b1;
      end
      BDMS_OP_COMF:
      begin
        alu.result = ~a;
        alu.upd_z = 1'b1;
      end
      BDMS_OP_RL:
      begin
        {alu.c, alu.result} = {a, carry_in};
        alu.upd_c = 1'b1;
      end
      BDMS_OP_RR:
      begin
        {alu.result, alu.c} = {carry_in, a};
        alu.upd_c = 1'b1;
      end
      BDMS_OP_CLR:
      begin
        alu.result = 8'h00;
        alu.upd_z = 1'b1;
      end
      BDMS_OP_MOVW: alu.result = w;
      BDMS_OP_BCLR:
      begin
        alu.result = a;
        alu.result[bit_idx] = 1'b0;
      end
      BDMS_OP_BSET:
      begin
        alu.result = a;
        alu.result[bit_idx] = 1'b1;
      end
      BDMS_OP_SWAP: alu.result = {a[3:0], a[7:4]};
      BDMS_OP_NONE: alu.result = a;
    endcase
    alu.z = (alu.result == 8'h00);
  end

endmodule

// file: hdl/bdms_top.sv
// banked data memory with status and indirect pointer registers
`timescale 1ns/1ps
module bdms_top
  import bdms_pkg::*;
#(
  parameter bdms_variant_e VARIANT = BDMS_VAR_MID
)
(
  input  wire logic      clock,
  input  wire logic      srst,
  input  bdms_req_s      req,
  input  wire logic      wdt_timeout,
  input  wire logic      sleep_enter,
  input  wire logic      wdt_clear,
  output bdms_rsp_s      rsp,
  output logic     [7:0] status,
  output logic     [7:0] ptr,
  output logic           bank_select
);

  logic [7:0]  status_q;
  logic [7:0]  status_d;
  logic [7:0]  ptr_q;
  logic [7:0]  ptr_d;
  bdms_rsp_s   rsp_q;
  bdms_rsp_s   rsp_d;
  logic [7:0]  eff_addr;
  logic [7:0]  operand;
  logic [7:0]  ram_rd;
  logic        ram_hit;
  logic        ram_we;
  logic        file_we;
  bdms_alu_s   alu;

  // 03h/83h and 04h/84h alias in both banks
  function automatic logic is_sfr(input logic [7:0] a, input logic [7:0] o);
    is_sfr = (a[6:0] == o[6:0]);
  endfunction

  function automatic logic in_sfr_area(input logic [7:0] a);
    in_sfr_area = (a[6:0] <= SFR_TOP);
  endfunction

  // indirect target comes straight from the pointer, not the bank bit
  always_comb
  begin
    if (req.indirect)
    begin
      eff_addr = ptr_q;
    end
    else
    begin
      eff_addr = {status_q[BIT_BANK_SEL], req.dir_addr};
    end
  end

  always_comb
  begin
    operand = 8'h00;
    if (req.use_literal)
    begin
      operand = req.literal;
    end
    else if (is_sfr(eff_addr, STATUS_OFS))
    begin
      operand = status_q;
    end
    else if (is_sfr(eff_addr, PTR_OFS))
    begin
      operand = ptr_q;
    end
    else if (!in_sfr_area(eff_addr))
    begin
      operand = ram_rd;
    end
  end

  bdms_alu_flags u_alu
  (
    .op       (req.op),
    .a        (operand),
    .w        (req.w_val),
    .bit_idx  (req.bit_idx),
    .carry_in (status_q[BIT_CARRY]),
    .alu      (alu)
  );

  assign file_we = req.valid && req.dest_file && !req.use_literal;
  assign ram_we  = file_we && !in_sfr_area(eff_addr);

  bdms_gpr_ram #(
    .VARIANT (VARIANT)
  ) u_ram
  (
    .clock   (clock),
    .addr    (eff_addr),
    .wr_en   (ram_we),
    .wr_data (alu.result),
    .rd_data (ram_rd),
    .hit     (ram_hit)
  );

  // status next value: data write first, then flag logic overrides
  always_comb
  begin
    status_d = status_q;
    if (file_we && is_sfr(eff_addr, STATUS_OFS))
    begin
      // top three bits take the data; 7:6 are kept by software at 0
      status_d[7:5] = alu.result[7:5];
      // any flag-updating op locks all three flag bits against data
      if (!(alu.upd_z || alu.upd_dc || alu.upd_c))
      begin
        status_d[BIT_ZERO:BIT_CARRY] = alu.result[BIT_ZERO:BIT_CARRY];
      end
    end
    if (req.valid && alu.upd_z)
    begin
      status_d[BIT_ZERO] = alu.z;
    end
    if (req.valid && alu.upd_dc)
    begin
      status_d[BIT_DIGIT] = alu.dc;
    end
    if (req.valid && alu.upd_c)
    begin
      status_d[BIT_CARRY] = alu.c;
    end
    // hardware events alone move these two bits
    if (wdt_clear)
    begin
      status_d[BIT_TIMEOUT]   = 1'b1;
      status_d[BIT_POWERDOWN] = 1'b1;
    end
    if (sleep_enter)
    begin
      status_d[BIT_TIMEOUT]   = 1'b1;
      status_d[BIT_POWERDOWN] = 1'b0;
    end
    if (wdt_timeout)
    begin
      status_d[BIT_TIMEOUT] = 1'b0;
    end
  end

  always_comb
  begin
    ptr_d = ptr_q;
    if (file_we && is_sfr(eff_addr, PTR_OFS))
    begin
      ptr_d = alu.result;
    end
  end

  always_comb
  begin
    rsp_d         = '0;
    rsp_d.valid   = req.valid;
    rsp_d.result  = alu.result;
    rsp_d.operand = operand;
    rsp_d.addr    = eff_addr;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      status_q <= STATUS_RESET;
      ptr_q    <= PTR_RESET;
      rsp_q    <= '0;
    end
    else
    begin
      status_q <= status_d;
      ptr_q    <= ptr_d;
      rsp_q    <= rsp_d;
    end
  end

  assign rsp         = rsp_q;
  assign status      = status_q;
  assign ptr         = ptr_q;
  assign bank_select = status_q[BIT_BANK_SEL];

endmodule

// file: sim/bdms_top_asserts.sv
// port-level assertions for the banked data memory top
`timescale 1ns/1ps
module bdms_top_chk
  import bdms_pkg::*;
(
  input wire logic       clock,
  input wire logic       srst,
  input bdms_req_s       req,
  input wire logic       wdt_timeout,
  input wire logic       sleep_enter,
  input wire logic       wdt_clear,
  input bdms_rsp_s       rsp,
  input wire logic [7:0] status,
  input wire logic [7:0] ptr,
  input wire logic       bank_select
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  wire quiet = !wdt_timeout && !sleep_enter && !wdt_clear;

  sequence s_add;
    req.valid && req.op == BDMS_OP_ADD;
  endsequence
  sequence s_sub;
    req.valid && req.op == BDMS_OP_SUB;
  endsequence
  sequence s_clr_stat;
    req.valid && req.op == BDMS_OP_CLR && !req.indirect
      && req.dir_addr == 7'h03 && req.dest_file && !req.use_literal;
  endsequence

  chk_bank_bit: assert property (
    !(req.valid && req.dest_file && !req.use_literal)
      |=> bank_select == $past(bank_select) && bank_select == status[5])
    else $error("bank select moved without a file write");
  chk_rsp_pulse: assert property (1'b1 |=> rsp.valid == $past(req.valid))
    else $error("response valid does not follow request");
  chk_addr_direct: assert property (
    req.valid && !req.indirect && !req.use_literal
      |=> rsp.addr == {$past(bank_select), $past(req.dir_addr)})
    else $error("effective address wrong");
  chk_flags_ro: assert property (
    quiet |=> status[4:3] == $past(status[4:3]))
    else $error("time-out or power-down bit changed");
  chk_timeout_clr: assert property (wdt_timeout |=> !status[4])
    else $error("time-out bit not cleared");
  chk_sleep_pd: assert property (
    sleep_enter && !wdt_timeout && !wdt_clear |=> status[4:3] == 2'b10)
    else $error("sleep entry flags wrong");
  chk_clr_status: assert property (s_clr_stat |=>
    status[7:5] == 3'b000 && status[2] && status[1:0] == $past(status[1:0]))
    else $error("status clear wrong");
  chk_zero_add: assert property (
    s_add |=> status[2] == (rsp.result == 8'h00))
    else $error("zero flag wrong after add");
  chk_carry_add: assert property (s_add |=> status[1:0] ==
    {({1'b0, rsp.operand[3:0]} + {1'b0, $past(req.w_val[3:0])}) > 5'h0F,
     ({1'b0, rsp.operand} + {1'b0, $past(req.w_val)}) > 9'h0FF})
    else $error("carry flags wrong after add");
  chk_sub_borrow: assert property (
    s_sub |=> status[0] == (rsp.operand >= $past(req.w_val)))
    else $error("borrow flag wrong after subtract");
endmodule

bind bdms_top bdms_top_chk u_chk (
  .clock(clock), .srst(srst), .req(req), .wdt_timeout(wdt_timeout),
  .sleep_enter(sleep_enter), .wdt_clear(wdt_clear), .rsp(rsp),
  .status(status), .ptr(ptr), .bank_select(bank_select));

// file: sim/bdms_core_model.sv
// behavioural core datapath issuing one data access per cycle
`timescale 1ns/1ps
module bdms_core_model
  import bdms_pkg::*;
(
  input wire logic clock,
  output bdms_req_s req
);
  initial req = '0;

  // entered just after a falling edge; returns after the taking edge
  task automatic issue(bdms_op_e op, logic [6:0] fa, logic [7:0] w,
                       logic dest, logic ind = 1'b0, logic [2:0] b = 3'h0);
    bdms_req_s r;
    r = '0;
    r.valid = 1'b1;
    r.op = op;
    r.dir_addr = fa;
    r.indirect = ind;
    r.bit_idx = b;
    r.dest_file = dest;
    // top two status bits never used as storage
    r.w_val = (op == BDMS_OP_MOVW && fa == 7'h03) ? {2'b00, w[5:0]} : w;
    req = r;
    @(negedge clock);
  endtask

  task automatic idle();
    req.valid = 1'b0;
    @(negedge clock);
  endtask
endmodule

// file: sim/testbench.sv
// self-checking bench for the banked data memory
`timescale 1ns/1ps
module testbench;
  import bdms_pkg::*;
  logic       clock;
  logic       srst;
  logic       wdt_timeout;
  logic       sleep_enter;
  logic       wdt_clear;
  bdms_req_s  req;
  bdms_rsp_s  rsp;
  bdms_rsp_s  rsp_l;
  bdms_rsp_s  rsp_o;
  logic [7:0] status;
  logic [7:0] ptr;
  logic       bank_select;
  int         miscompares = 0;
  int         num_checks = 0;
  int         cycles = 0;
  logic [2:0] ev_in [4] = '{3'b100, 3'b010, 3'b110, 3'b001};
  logic [7:0] ev_exp [4] = '{8'h0E, 8'h16, 8'h06, 8'h1E};

  bdms_top #(.VARIANT(BDMS_VAR_MID)) dut (
    .clock(clock), .srst(srst), .req(req), .wdt_timeout(wdt_timeout),
    .sleep_enter(sleep_enter), .wdt_clear(wdt_clear), .rsp(rsp),
    .status(status), .ptr(ptr), .bank_select(bank_select));
  bdms_top #(.VARIANT(BDMS_VAR_LARGE)) dut_large (
    .clock(clock), .srst(srst), .req(req), .wdt_timeout(wdt_timeout),
    .sleep_enter(sleep_enter), .wdt_clear(wdt_clear), .rsp(rsp_l),
    .status(), .ptr(), .bank_select());
  bdms_top #(.VARIANT(BDMS_VAR_OLD)) dut_old (
    .clock(clock), .srst(srst), .req(req), .wdt_timeout(wdt_timeout),
    .sleep_enter(sleep_enter), .wdt_clear(wdt_clear), .rsp(rsp_o),
    .status(), .ptr(), .bank_select());
  bdms_core_model core (.clock(clock), .req(req));

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic check(logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // swap without write-back reads the file and leaves the flags alone
  task automatic rd(logic [6:0] fa, logic [7:0] exp);
    core.issue(BDMS_OP_SWAP, fa, 8'h00, 1'b0);
    check(rsp.operand, exp);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 500)
    begin
      miscompares++;
      final_report();
    end
  end

  initial
  begin
    srst = 1'b1;
    {wdt_timeout, sleep_enter, wdt_clear} = 3'b000;
    repeat (2) @(negedge clock);
    srst = 1'b0;
    check(status, 8'h18);
    check(ptr, 8'h00);
    $display("test reset done");
    core.issue(BDMS_OP_MOVW, 7'h20, 8'h5A, 1'b1);
    rd(7'h20, 8'h5A);
    core.issue(BDMS_OP_MOVW, 7'h10, 8'hA5, 1'b1);
    rd(7'h10, 8'h00);
    core.issue(BDMS_OP_MOVW, 7'h70, 8'h3C, 1'b1);
    core.issue(BDMS_OP_BSET, 7'h03, 8'h00, 1'b1, 1'b0, 3'd5);
    check({7'h00, bank_select}, 8'h01);
    rd(7'h70, 8'h3C);
    check(rsp_o.operand, 8'h00);
    core.issue(BDMS_OP_MOVW, 7'h20, 8'h66, 1'b1);
    rd(7'h20, 8'h00);
    check(rsp_l.operand, 8'h66);
    rd(7'h03, 8'h38);
    check(rsp.addr, 8'h83);
    core.issue(BDMS_OP_BCLR, 7'h03, 8'h00, 1'b1, 1'b0, 3'd5);
    $display("test map done");
    core.issue(BDMS_OP_MOVW, 7'h04, 8'h21, 1'b1);
    check(ptr, 8'h21);
    check({7'h00, rsp.valid}, 8'h01);
    core.issue(BDMS_OP_MOVW, 7'h00, 8'h77, 1'b1, 1'b1);
    rd(7'h21, 8'h77);
    $display("test indirect done");
    core.issue(BDMS_OP_MOVW, 7'h22, 8'hFF, 1'b1);
    core.issue(BDMS_OP_ADD, 7'h22, 8'h01, 1'b1);
    check(status, 8'h1F);
    core.issue(BDMS_OP_SUB, 7'h22, 8'h01, 1'b1);
    check(status, 8'h18);
    core.issue(BDMS_OP_RL, 7'h22, 8'h00, 1'b1);
    check(rsp.result, 8'hFE);
    check(status, 8'h19);
    $display("test flags done");
    core.issue(BDMS_OP_MOVW, 7'h03, 8'h07, 1'b1);
    check(status, 8'h1F);
    core.issue(BDMS_OP_ADD, 7'h03, 8'h01, 1'b1);
    check(status, 8'h3A);
    core.issue(BDMS_OP_CLR, 7'h03, 8'h00, 1'b1);
    check(status, 8'h1E);
    core.idle();
    check({7'h00, rsp.valid}, 8'h00);
    foreach (ev_in[i])
    begin
      {wdt_timeout, sleep_enter, wdt_clear} = ev_in[i];
      @(negedge clock);
      check(status, ev_exp[i]);
    end
    {wdt_timeout, sleep_enter, wdt_clear} = 3'b000;
    srst = 1'b1;
    @(negedge clock);
    srst = 1'b0;
    check(status, 8'h18);
    $display("test status done");
    final_report();
  end
endmodule
